// ===== include/tim_consts.vh
// register offsets, field positions and reset values for the tx interrupt / rx teardown block
// assumes a 32-bit axi4-lite register slave with word-aligned registers
`ifndef TIM_CONSTS_VH
`define TIM_CONSTS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define TIM_OFF_RX_TEARDOWN 12'h018
`define TIM_OFF_TX_RAW 12'h080
`define TIM_OFF_TX_MASKED 12'h084
`define TIM_OFF_TX_MASK_SET 12'h088
`define TIM_OFF_TX_MASK_CLEAR 12'h08c
`define TIM_OFF_VECTOR 12'h090
`define TIM_OFF_EVT_STATUS 12'h0a0
`define TIM_OFF_EVT_ENABLE 12'h0a4
`define TIM_OFF_EVT_CLEAR 12'h0a8

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define TIM_TDN_CH_MSB 2
`define TIM_VEC_TX_LSB 16
`define TIM_MASK_RESET 8'h00
`define TIM_EVT_RESET 2'h0
`define TIM_EVT_BIT_TDN 0
`define TIM_EVT_BIT_TX 1

// ------------------------------------------------------------
// axi response codes
// ------------------------------------------------------------
`define TIM_RESP_OKAY 2'b00
`define TIM_RESP_SLVERR 2'b10

`endif

// ===== design/tim_sync.v
// two-flop synchroniser for a bus of asynchronous levels
// assumes the inputs come from another clock domain or a pin
`timescale 1ns/10ps
module tim_sync #(
   parameter WIDTH = 8
) (
   input wire aclk,
   input wire aresetn,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] stage1;

   // first stage only feeds the second, to contain metastability
   always @(posedge aclk) begin
      if (!aresetn) begin
         stage1 <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule

// ===== design/tim_event_regs.v
// sticky event status with enable and write-one-to-clear, one level interrupt out
// assumes one-cycle event pulses and one-cycle write strobes on the same clock
`timescale 1ns/10ps
`include "tim_consts.vh"
module tim_event_regs #(
   parameter WIDTH = 2
) (
   input wire aclk,
   input wire aresetn,
   input wire [WIDTH-1:0] event_pulse,
   input wire enable_we,
   input wire clear_we,
   input wire [WIDTH-1:0] wdata,
   output reg [WIDTH-1:0] status,
   output reg [WIDTH-1:0] enable,
   output reg irq
);

   wire [WIDTH-1:0] next_status;

   // a new event wins over a clear in the same cycle so nothing is lost
   assign next_status = (status & ~(clear_we ? wdata : {WIDTH{1'b0}})) | event_pulse;

   always @(posedge aclk) begin
      if (!aresetn) begin
         status <= {WIDTH{1'b0}};
         enable <= {WIDTH{1'b0}};
         irq <= 1'b0;
      end else begin
         status <= next_status;
         if (enable_we) begin
            enable <= wdata;
         end
         irq <= |(next_status & (enable_we ? wdata : enable));
      end
   end

endmodule

// ===== design/tim_tx_irq_teardown.v
// tx interrupt mask/status registers and rx teardown command, axi4-lite slave
// assumes tx pending levels arrive from another domain; teardown pulse goes to the rx dma
// assumes a synchronous active-low reset held for two edges or more
// assumes the bus master keeps one write and one read in flight at most
// assumes eight tx channels; the vector and the status words have room for no more
// How it works
// R01: writing channel 0..7 to bits 2..0 of teardown register starts that rx teardown
// R02: reading the rx teardown command register always returns zero
// R03: raw tx status bit n shows channel n pending before masking
// R04: masked tx status bit n shows pending only when channel n enabled
// R05: mask set writes enable channels where a one is written, zeros ignored
// R06: mask clear writes disable channels where a one is written, zeros ignored
// R07: set and clear act on eight mask bits, seven down to zero
// R08: tx pending flags appear in vector bits 23..16, bit 16 is channel 0
// R09: mask set and clear reads return the mask, upper bits zero
`timescale 1ns/10ps
`include "tim_consts.vh"
module tim_tx_irq_teardown #(
   parameter NCHAN = 8
) (
   input wire aclk,
   input wire aresetn,
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [NCHAN-1:0] tx_pending_in,
   output reg teardown_start,
   output reg [2:0] teardown_channel_select,
   output reg [NCHAN-1:0] tx_irq_line,
   output reg irq
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------

   // widen an eight-bit field to a bus word with zero upper bits
   function [31:0] zext8;
      input [7:0] v;
      begin
         zext8 = {24'h000000, v};
      end
   endfunction

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------

   // register map, in address order:
   //   teardown command: write only, the low byte lane carries the channel
   //   raw tx status: read only
   //   masked tx status: read only
   //   mask set: write one to enable, reads back the mask
   //   mask clear: write one to disable, reads back the mask
   //   vector: read only, tx pending in the third byte
   //   event status: read only, sticky until cleared
   //   event enable: read and write
   //   event clear: write one to clear, reads zero
   localparam SEL_TDN = 0;
   localparam SEL_RAW = 1;
   localparam SEL_MSK = 2;
   localparam SEL_SET = 3;
   localparam SEL_CLR = 4;
   localparam SEL_VEC = 5;
   localparam SEL_EST = 6;
   localparam SEL_EEN = 7;
   localparam SEL_ECL = 8;
   localparam NSEL = 9;

   // one-hot select of the word at a byte address; the byte lane bits are ignored
   function [NSEL-1:0] reg_sel;
      input [11:0] a;
      begin
         reg_sel = {NSEL{1'b0}};
         case ({a[11:2], 2'b00})
            `TIM_OFF_RX_TEARDOWN: reg_sel[SEL_TDN] = 1'b1;
            `TIM_OFF_TX_RAW: reg_sel[SEL_RAW] = 1'b1;
            `TIM_OFF_TX_MASKED: reg_sel[SEL_MSK] = 1'b1;
            `TIM_OFF_TX_MASK_SET: reg_sel[SEL_SET] = 1'b1;
            `TIM_OFF_TX_MASK_CLEAR: reg_sel[SEL_CLR] = 1'b1;
            `TIM_OFF_VECTOR: reg_sel[SEL_VEC] = 1'b1;
            `TIM_OFF_EVT_STATUS: reg_sel[SEL_EST] = 1'b1;
            `TIM_OFF_EVT_ENABLE: reg_sel[SEL_EEN] = 1'b1;
            `TIM_OFF_EVT_CLEAR: reg_sel[SEL_ECL] = 1'b1;
            default: reg_sel = {NSEL{1'b0}};
         endcase
      end
   endfunction

   // true when the offset is one of the mapped registers
   function mapped;
      input [11:0] a;
      begin
         mapped = |reg_sel(a);
      end
   endfunction

   // ------------------------------------------------------------
   // pending inputs and mask
   // ------------------------------------------------------------
   wire [NCHAN-1:0] tx_pend;
   reg [NCHAN-1:0] tx_mask;
   reg [NCHAN-1:0] tx_pend_q;
   wire [1:0] evt_status;
   wire [1:0] evt_enable;
   wire evt_irq;

   // pending levels come from the tx engine's domain: two flops before any use
   tim_sync #(
      .WIDTH(NCHAN)
   ) i_tim_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(tx_pending_in),
      .sync_out(tx_pend)
   );

   // ------------------------------------------------------------
   // write channel: address and data taken in either order
   // ------------------------------------------------------------
   reg aw_held;
   reg w_held;
   reg [11:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire do_write;
   wire [7:0] wlow;

   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign wlow = w_strb[0] ? w_data[7:0] : 8'h00;

   // address half: awready pulses while the half is free, so a waiting master
   // loses one cycle at most; held until the pair has been answered
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 12'h000;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[11:2], 2'b00};
            s_axi_awready <= 1'b0;
         end
         if (do_write) begin
            aw_held <= 1'b0;
         end
      end
   end

   // data half: only the low byte lane is used later, but the word is kept whole
   always @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_held && !s_axi_wready;
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // response: one answer per pair; bvalid blocks the next pair until it is taken
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TIM_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= mapped(aw_addr) ? `TIM_RESP_OKAY : `TIM_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // register effects of writes
   // ------------------------------------------------------------
   wire [NSEL-1:0] wsel;
   wire wr_tdn;
   wire wr_set;
   wire wr_clr;
   wire wr_een;
   wire wr_ecl;

   // decode the held address once; every strobe lasts the single do_write cycle
   assign wsel = do_write ? reg_sel(aw_addr) : {NSEL{1'b0}};
   // a teardown without its low byte lane carries no channel, so it is dropped
   assign wr_tdn = wsel[SEL_TDN] && w_strb[0]; // [R01]
   assign wr_set = wsel[SEL_SET];
   assign wr_clr = wsel[SEL_CLR];
   assign wr_een = wsel[SEL_EEN];
   assign wr_ecl = wsel[SEL_ECL];

   // set and clear in one cycle cannot happen: one write at a time
   always @(posedge aclk) begin
      if (!aresetn) begin
         tx_mask <= `TIM_MASK_RESET;
      end else if (wr_set) begin
         tx_mask <= tx_mask | wlow[NCHAN-1:0]; // [R05] [R07]
      end else if (wr_clr) begin
         tx_mask <= tx_mask & ~wlow[NCHAN-1:0]; // [R06] [R07]
      end
   end

   // command is a one-cycle pulse; nothing is stored for readback, so the
   // channel output keeps the last command only for the receive engine
   always @(posedge aclk) begin
      if (!aresetn) begin
         teardown_start <= 1'b0;
         teardown_channel_select <= 3'h0;
      end else begin
         teardown_start <= wr_tdn; // [R01]
         if (wr_tdn) begin
            teardown_channel_select <= w_data[`TIM_TDN_CH_MSB:0]; // [R01]
         end
      end
   end

   // ------------------------------------------------------------
   // outputs and rising-edge events for the sticky status
   // ------------------------------------------------------------
   wire [NCHAN-1:0] tx_rise_vec;
   wire tx_rise;
   wire [7:0] vector_tx_pending_field;

   // only a rise of an enabled channel is an event; a level already high at enable is not
   assign tx_rise_vec = tx_pend & ~tx_pend_q & tx_mask;
   assign tx_rise = |tx_rise_vec;
   // the vector shows the same synchronised flags as the raw status, channel 0 lowest
   assign vector_tx_pending_field = tx_pend; // [R08]

   // previous pending levels for the rise detector; reset matches the idle low pins
   always @(posedge aclk) begin
      if (!aresetn) begin
         tx_pend_q <= {NCHAN{1'b0}};
      end else begin
         tx_pend_q <= tx_pend;
      end
   end

   // outputs come from flops; irq adds one edge to the event logic's own flop
   always @(posedge aclk) begin
      if (!aresetn) begin
         tx_irq_line <= {NCHAN{1'b0}};
         irq <= 1'b0;
      end else begin
         tx_irq_line <= tx_pend & tx_mask; // [R04]
         irq <= evt_irq;
      end
   end

   // ------------------------------------------------------------
   // sticky events and the level interrupt
   // ------------------------------------------------------------

   // bit 0 marks a teardown command, bit 1 a rise of an enabled tx channel
   tim_event_regs #(
      .WIDTH(2)
   ) i_tim_event_regs (
      .aclk(aclk),
      .aresetn(aresetn),
      .event_pulse({tx_rise, wr_tdn}),
      .enable_we(wr_een),
      .clear_we(wr_ecl),
      .wdata(w_data[1:0]),
      .status(evt_status),
      .enable(evt_enable),
      .irq(evt_irq)
   );

   // ------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------
   reg [31:0] next_rdata;

   // read mux; write-only and unmapped words read zero
   always @* begin
      next_rdata = 32'h00000000;
      case ({s_axi_araddr[11:2], 2'b00})
         `TIM_OFF_RX_TEARDOWN: next_rdata = 32'h00000000; // [R02]
         `TIM_OFF_TX_RAW: next_rdata = zext8(tx_pend); // [R03]
         `TIM_OFF_TX_MASKED: next_rdata = zext8(tx_pend & tx_mask); // [R04]
         `TIM_OFF_TX_MASK_SET: next_rdata = zext8(tx_mask); // [R09]
         `TIM_OFF_TX_MASK_CLEAR: next_rdata = zext8(tx_mask); // [R09]
         `TIM_OFF_VECTOR: next_rdata = {8'h00, vector_tx_pending_field, 16'h0000}; // [R08]
         `TIM_OFF_EVT_STATUS: next_rdata = {30'h0, evt_status};
         `TIM_OFF_EVT_ENABLE: next_rdata = {30'h0, evt_enable};
         default: next_rdata = 32'h00000000;
      endcase
   end

   wire ar_take;
   wire [NSEL-1:0] rsel;

   assign ar_take = s_axi_arvalid && s_axi_arready;
   assign rsel = reg_sel(s_axi_araddr);

   // one read in flight; arready pulses only while no data is waiting
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      end
   end

   // data and code are caught at the address edge and stand until rready
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `TIM_RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= (|rsel) ? `TIM_RESP_OKAY : `TIM_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// ===== tb/tim_tx_irq_teardown_checker.sv
// concurrent checks for the tx interrupt / rx teardown block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
`include "tim_consts.vh"
module tim_tx_irq_checker #(
   parameter NCHAN = 8
) (
   input wire aclk,
   input wire aresetn,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [NCHAN-1:0] tx_pending_in,
   input wire teardown_start,
   input wire [NCHAN-1:0] tx_irq_line,
   input wire irq
);
   reg [11:0] last_ar;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // read data answers the address taken one edge earlier
   always @(posedge aclk) begin
      if (!aresetn) begin
         last_ar <= 12'h000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         last_ar <= s_axi_araddr;
      end
   end
   wire rd_ok = s_axi_rvalid && (s_axi_rresp == `TIM_RESP_OKAY);
   wire rd_mask = (last_ar == `TIM_OFF_TX_MASK_SET) || (last_ar == `TIM_OFF_TX_MASK_CLEAR);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   property p_td_pulse; teardown_start |=> !teardown_start; endproperty
   a_td_pulse: assert property (p_td_pulse) else $error("teardown pulse too long");
   property p_td_resp; teardown_start |-> s_axi_bvalid; endproperty
   a_td_resp: assert property (p_td_resp) else $error("teardown without response");
   property p_td_zero; s_axi_rvalid && last_ar == `TIM_OFF_RX_TEARDOWN |-> s_axi_rdata == 0;
   endproperty
   a_td_zero: assert property (p_td_zero) else $error("teardown read not zero");
   property p_raw_hi; rd_ok && last_ar == `TIM_OFF_TX_RAW |-> s_axi_rdata[31:8] == 0; endproperty
   a_raw_hi: assert property (p_raw_hi) else $error("raw upper bits set");
   property p_line_sub; (tx_irq_line & ~$past(tx_pending_in, 3)) == 0; endproperty
   a_line_sub: assert property (p_line_sub) else $error("irq line without pending");
   property p_msk_hi; rd_ok && last_ar == `TIM_OFF_TX_MASKED |-> s_axi_rdata[31:8] == 0;
   endproperty
   a_msk_hi: assert property (p_msk_hi) else $error("masked upper bits set");
   property p_set_hi; rd_ok && rd_mask |-> s_axi_rdata[31:8] == 0; endproperty
   a_set_hi: assert property (p_set_hi) else $error("mask upper bits set");
   property p_vec; rd_ok && last_ar == `TIM_OFF_VECTOR |-> {s_axi_rdata[31:24],
      s_axi_rdata[15:0]} == 0; endproperty
   a_vec: assert property (p_vec) else $error("vector bits outside tx field");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   cover property (teardown_start);
   cover property ($rose(irq));
   cover property (s_axi_rvalid && s_axi_rresp == `TIM_RESP_SLVERR);
endmodule
bind tim_tx_irq_teardown tim_tx_irq_checker #(.NCHAN(NCHAN)) i_tim_tx_irq_checker (.aclk,
   .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .tx_pending_in,
   .teardown_start, .tx_irq_line, .irq);

// ===== tb/tim_tx_irq_teardown_tb_top.sv
// self-checking bench for the tx interrupt / rx teardown block
// assumes a single 25 mhz clock and an axi4-lite master driven here
`timescale 1ns/10ps
`include "tim_consts.vh"
module tim_tx_irq_teardown_tb_top;
   reg aclk = 1'b0;
   reg aresetn = 1'b0;
   reg [11:0] s_axi_awaddr = 12'h000;
   reg [11:0] s_axi_araddr = 12'h000;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_wstrb = 4'h0;
   reg s_axi_awvalid = 1'b0;
   reg s_axi_wvalid = 1'b0;
   reg s_axi_bready = 1'b0;
   reg s_axi_arvalid = 1'b0;
   reg s_axi_rready = 1'b0;
   reg [7:0] tx_pending_in = 8'h00;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire teardown_start, irq;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [2:0] teardown_channel_select;
   wire [7:0] tx_irq_line;
   int n_errors = 0;
   int comparisons = 0;
   int td_count = 0;
   reg [2:0] td_last = 3'h0;
   reg [31:0] rd;
   reg [1:0] rs;
   tim_tx_irq_teardown #(.NCHAN(8)) i_tim_tx_irq_teardown (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_pending_in, .teardown_start,
      .teardown_channel_select, .tx_irq_line, .irq);
   always #20 aclk = ~aclk;
   // count teardown pulses so a lost or doubled pulse shows up
   always @(posedge aclk) begin
      if (teardown_start) begin
         td_count <= td_count + 1;
         td_last <= teardown_channel_select;
      end
   end
   // ------------------------------------------------------------
   // bus and compare tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input [31:0] seen, input [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // address and data offered together, each released when taken
   task automatic wr(input [11:0] a, input [31:0] d, input [3:0] s);
      bit aw;
      bit w;
      aw = 0;
      w = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (!aw && s_axi_awready) begin
            aw = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
      end while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rdt(input [11:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
         end
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic rchk(input [11:0] a, input [31:0] exp, input string nm);
      rdt(a);
      chk(nm, rd, exp);
      chk("rresp", rs, `TIM_RESP_OKAY);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_teardown;
      for (int c = 0; c < 8; c++) begin
         wr(`TIM_OFF_RX_TEARDOWN, 32'hfffffff8 | c, 4'hf);
         repeat (2) @(posedge aclk);
         chk("td count", td_count, c + 1);
         chk("td chan", td_last, c);
         rchk(`TIM_OFF_RX_TEARDOWN, 32'h0, "td read");
      end
      // low byte strobe off: command must be dropped
      wr(`TIM_OFF_RX_TEARDOWN, 32'h3, 4'he);
      repeat (2) @(posedge aclk);
      chk("td ignored", td_count, 8);
   endtask
   task automatic t_mask;
      rchk(`TIM_OFF_TX_MASK_SET, 32'h0, "mask reset");
      wr(`TIM_OFF_TX_MASK_SET, 32'h000000a5, 4'hf);
      rchk(`TIM_OFF_TX_MASK_SET, 32'ha5, "set");
      wr(`TIM_OFF_TX_MASK_SET, 32'hffffff00, 4'hf);
      rchk(`TIM_OFF_TX_MASK_CLEAR, 32'ha5, "set zeros");
      wr(`TIM_OFF_TX_MASK_CLEAR, 32'h00000081, 4'hf);
      rchk(`TIM_OFF_TX_MASK_SET, 32'h24, "clear");
      wr(`TIM_OFF_TX_MASK_CLEAR, 32'hffffff00, 4'hf);
      rchk(`TIM_OFF_TX_MASK_CLEAR, 32'h24, "clear zeros");
   endtask
   task automatic t_pending;
      @(posedge aclk);
      tx_pending_in <= 8'h3c;
      repeat (5) @(posedge aclk);
      rchk(`TIM_OFF_TX_RAW, 32'h3c, "raw");
      rchk(`TIM_OFF_TX_MASKED, 32'h24, "masked");
      chk("irq line", tx_irq_line, 8'h24);
      rchk(`TIM_OFF_VECTOR, 32'h003c0000, "vector");
      wr(`TIM_OFF_TX_MASK_SET, 32'hff, 4'hf);
      rchk(`TIM_OFF_TX_MASKED, 32'h3c, "all set");
      wr(`TIM_OFF_TX_MASK_CLEAR, 32'hff, 4'hf);
      rchk(`TIM_OFF_TX_MASKED, 32'h0, "all clear");
   endtask
   // sticky teardown event drives irq only while enabled
   task automatic t_irq;
      wr(`TIM_OFF_EVT_CLEAR, 32'h3, 4'hf);
      rchk(`TIM_OFF_EVT_STATUS, 32'h0, "evt cleared");
      wr(`TIM_OFF_EVT_ENABLE, 32'h1, 4'hf);
      wr(`TIM_OFF_RX_TEARDOWN, 32'h5, 4'hf);
      repeat (3) @(posedge aclk);
      chk("irq on", irq, 1'b1);
      wr(`TIM_OFF_EVT_ENABLE, 32'h0, 4'hf);
      repeat (3) @(posedge aclk);
      chk("irq masked", irq, 1'b0);
      wr(`TIM_OFF_EVT_ENABLE, 32'h1, 4'hf);
      wr(`TIM_OFF_EVT_CLEAR, 32'h1, 4'hf);
      repeat (3) @(posedge aclk);
      chk("irq cleared", irq, 1'b0);
      rdt(12'h0fc);
      chk("unmapped rd", rd, 32'h0);
      chk("unmapped rresp", rs, `TIM_RESP_SLVERR);
      wr(12'h0fc, 32'h1, 4'hf);
      chk("unmapped wr", rs, `TIM_RESP_SLVERR);
   endtask
   task automatic stop_test;
      if (n_errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // watchdog: the whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge aclk);
      n_errors++;
      stop_test;
   end
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_teardown;
      t_mask;
      t_pending;
      t_irq;
      // second reset in mid-run must clear a mask that is not already clear
      wr(`TIM_OFF_TX_MASK_SET, 32'h0000005a, 4'hf);
      rchk(`TIM_OFF_TX_MASK_SET, 32'h5a, "mask before reset");
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(`TIM_OFF_TX_MASK_SET, 32'h0, "mask after reset");
      chk("line after reset", tx_irq_line, 8'h00);
      stop_test;
   end
endmodule
